// file: hdl/gcs_pkg.sv
package gcs_pkg;
  // ==========================================================================
  // link byte addresses
  localparam logic [7:0] GCS_ADDR_CTRL_LO = 8'h00;
  localparam logic [7:0] GCS_ADDR_CTRL_HI = 8'h01;
  localparam logic [7:0] GCS_ADDR_TEMP_LO = 8'h02;
  localparam logic [7:0] GCS_ADDR_TEMP_HI = 8'h03;
  localparam logic [7:0] GCS_ADDR_VOLT_LO = 8'h04;
  localparam logic [7:0] GCS_ADDR_VOLT_HI = 8'h05;

  // ==========================================================================
  // control subcommand codes, then the last-command limit
  localparam logic [15:0] GCS_SC_FW_REV      = 16'h0002;
  localparam logic [15:0] GCS_SC_LAST_CMD    = 16'h0007;
  localparam logic [15:0] GCS_SC_PROFILE     = 16'h0008;
  localparam logic [15:0] GCS_SC_PRES_ASSERT = 16'h000c;
  localparam logic [15:0] GCS_SC_PRES_DEASRT = 16'h000d;
  localparam logic [15:0] GCS_SC_LOWPOW_INV  = 16'h0010;
  localparam logic [15:0] GCS_SC_SLEEP_REQ   = 16'h0011;
  localparam logic [15:0] GCS_SC_SLEEP_CAN   = 16'h0012;
  localparam logic [15:0] GCS_SC_CFG_ENTER   = 16'h0013;
  localparam logic [15:0] GCS_SC_PDN_ARM     = 16'h001b;
  localparam logic [15:0] GCS_SC_PDN_GO      = 16'h001c;
  localparam logic [15:0] GCS_SC_SEAL        = 16'h0020;
  localparam logic [15:0] GCS_SC_OUT_PULSE   = 16'h0023;
  localparam logic [15:0] GCS_SC_ALT_ONE     = 16'h0031;
  localparam logic [15:0] GCS_SC_ALT_TWO     = 16'h0032;
  localparam logic [15:0] GCS_SC_FULL_RST    = 16'h0041;
  localparam logic [15:0] GCS_SC_SOFT_RST    = 16'h0042;
  localparam logic [15:0] GCS_SC_CFG_PLAIN   = 16'h0043;
  localparam logic [15:0] GCS_SC_CFG_RESIM   = 16'h0044;
  localparam logic [15:0] GCS_LAST_LIMIT     = 16'h0015;

  // ==========================================================================
  // limits, snapshot layout and timing
  localparam logic [15:0] GCS_VOLT_MAX_MV = 16'h1770;
  localparam int          GCS_SNAP_W      = 48;
  localparam int          GCS_SNAP_RESP   = 0;
  localparam int          GCS_SNAP_TEMP   = 16;
  localparam int          GCS_SNAP_VOLT   = 32;
  localparam int          GCS_CLK_PER_PS  = 5000;
  localparam int          GCS_PULSE_NS    = 1000000;
  localparam int          GCS_PULSE_CYC   = (GCS_PULSE_NS * 1000) / GCS_CLK_PER_PS;

  // ==========================================================================
  // selected chemistry profile
  typedef enum logic [1:0] {GCS_CHEM_BASE, GCS_CHEM_ALT1, GCS_CHEM_ALT2} gcs_chem_e;
endpackage

// file: hdl/gcs_subcommand_unit.sv
module gcs_subcommand_unit
  import gcs_pkg::*;
#(
  parameter int          PULSE_W     = GCS_PULSE_CYC,
  parameter logic [15:0] FW_REVISION = 16'h0101,  // arbitrary value
  parameter logic [15:0] PROFILE_ID0 = 16'h0a01,  // arbitrary value
  parameter logic [15:0] PROFILE_ID1 = 16'h0a02,  // arbitrary value
  parameter logic [15:0] PROFILE_ID2 = 16'h0a03   // arbitrary value
) (
  // system clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // link side, on the link clock
  input  wire logic        link_clk_in,
  input  wire logic        link_wr_in,
  input  wire logic        link_rd_in,
  input  wire logic [7:0]  link_addr_in,
  input  wire logic [7:0]  link_wdata_in,
  output logic      [7:0]  link_rdata_out,
  // configuration and measurement, system clock domain
  input  wire logic        pin_presence_detect_enable_in,
  input  wire logic        host_temperature_select_in,
  input  wire logic        low_battery_output_option_in,
  input  wire logic        charge_int_function_in,
  input  wire logic [15:0] internal_temp_in,
  input  wire logic [15:0] pack_voltage_in,
  input  wire logic        sleep_detected_in,
  input  wire logic        hibernate_exit_in,
  input  wire logic        ram_update_done_in,
  input  wire logic        init_done_in,
  // pins, asynchronous
  input  wire logic        battery_insert_pin_in,
  input  wire logic        general_output_pin_in,
  output logic             general_output_pin_out,
  output logic             general_output_pin_oe_n_out,
  // status
  output logic             battery_present_flag_out,
  output logic             gauging_active_out,
  output logic             min_power_bit_out,
  output logic             deep_sleep_request_out,
  output logic             hibernate_active_out,
  output logic             config_mode_flag_out,
  output logic             powerdown_armed_bit_out,
  output logic             powerdown_active_out,
  output logic             sealed_out,
  output logic             profile_change_pending_bit_out,
  output logic             power_on_reset_flag_out,
  output logic             init_mode_out,
  output logic [1:0]       profile_select_out,
  // one-cycle action pulses
  output logic             full_reset_out,
  output logic             ocv_measure_out,
  output logic             resimulate_out
);

  localparam int PULSE_CW = $clog2(PULSE_W + 1);

  // ==========================================================================
  // state types
  typedef struct packed {
    logic [7:0]          cmd_lo;
    logic [7:0]          temp_lo;
    logic [15:0]         resp;
    logic [15:0]         last;
    logic [15:0]         temp_host;
    logic                battery_present_flag;
    logic                min_pow;
    logic                hib_req;
    logic                hib_act;
    logic                cfg;
    logic                armed;
    logic                pdn;
    logic                sealed;
    gcs_chem_e           chem;
    logic                chem_chg;
    logic                por;
    logic                init;
    logic                gauging;
    logic                full_rst;
    logic                ocv;
    logic                resim;
    logic [PULSE_CW-1:0] pulse_cnt;
    logic                gp_oe_n;
    logic                bin_s1;
    logic                bin_s2;
    logic                bin_s3;
    logic                gp_s1;
    logic                gp_s2;
    logic                gp_s3;
    logic                rx_s1;
    logic                rx_s2;
    logic                rx_s3;
    logic                ack_s1;
    logic                ack_s2;
    logic                snap_tgl;
    logic [GCS_SNAP_W-1:0] snap;
  } gcs_sys_s;

  typedef struct packed {
    logic                  wr_tgl;
    logic [7:0]            waddr;
    logic [7:0]            wdata;
    logic                  snap_s1;
    logic                  snap_s2;
    logic                  ack;
    logic [GCS_SNAP_W-1:0] snap;
    logic [7:0]            rdata;
  } gcs_link_s;

  gcs_sys_s  s_r, s_nxt;
  gcs_link_s l_r, l_nxt;
  logic        wr_evt;
  logic        ctl_fire;
  logic [15:0] code;
  logic        restore;
  logic        open_ok;
  logic [15:0] volt_clamped;
  logic [15:0] temp_rd;

  // ==========================================================================
  // link domain: byte writes go out by toggle, reads come from the snapshot
  always_comb begin
    l_nxt         = l_r;
    l_nxt.snap_s1 = s_r.snap_tgl;
    l_nxt.snap_s2 = l_r.snap_s1;
    if (l_r.snap_s2 != l_r.ack) begin
      l_nxt.snap = s_r.snap;   // sys holds snapshot stable until ack returns
      l_nxt.ack  = l_r.snap_s2;
    end
    if (link_wr_in) begin
      l_nxt.waddr  = link_addr_in;
      l_nxt.wdata  = link_wdata_in;
      l_nxt.wr_tgl = ~l_r.wr_tgl;
    end
    if (link_rd_in) begin
      case (link_addr_in)
        GCS_ADDR_CTRL_LO: l_nxt.rdata = l_r.snap[GCS_SNAP_RESP +: 8];
        GCS_ADDR_CTRL_HI: l_nxt.rdata = l_r.snap[GCS_SNAP_RESP + 8 +: 8];
        GCS_ADDR_TEMP_LO: l_nxt.rdata = l_r.snap[GCS_SNAP_TEMP +: 8];
        GCS_ADDR_TEMP_HI: l_nxt.rdata = l_r.snap[GCS_SNAP_TEMP + 8 +: 8];
        GCS_ADDR_VOLT_LO: l_nxt.rdata = l_r.snap[GCS_SNAP_VOLT +: 8];
        GCS_ADDR_VOLT_HI: l_nxt.rdata = l_r.snap[GCS_SNAP_VOLT + 8 +: 8];
        default:          l_nxt.rdata = 8'h00;
      endcase
    end
  end

  // link registers
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ==========================================================================
  // system domain helpers
  assign wr_evt       = s_r.rx_s2 != s_r.rx_s3;
  assign ctl_fire     = wr_evt && (l_r.waddr == GCS_ADDR_CTRL_HI) && !s_r.pdn;
  assign code         = {l_r.wdata, s_r.cmd_lo};
  assign open_ok      = !s_r.sealed;
  assign volt_clamped = (pack_voltage_in > GCS_VOLT_MAX_MV) ? GCS_VOLT_MAX_MV : pack_voltage_in;
  assign temp_rd      = host_temperature_select_in ? s_r.temp_host : internal_temp_in;

  // command decode, status flags, pin handling and snapshot refresh
  always_comb begin
    s_nxt          = s_r;
    restore        = 1'b0;
    s_nxt.full_rst = 1'b0;
    s_nxt.ocv      = 1'b0;
    s_nxt.resim    = 1'b0;
    // two-flop synchronisers, third flop only for edge detection
    s_nxt.bin_s1 = battery_insert_pin_in;
    s_nxt.bin_s2 = s_r.bin_s1;
    s_nxt.bin_s3 = s_r.bin_s2;
    s_nxt.gp_s1  = general_output_pin_in;
    s_nxt.gp_s2  = s_r.gp_s1;
    s_nxt.gp_s3  = s_r.gp_s2;
    s_nxt.rx_s1  = l_r.wr_tgl;
    s_nxt.rx_s2  = s_r.rx_s1;
    s_nxt.rx_s3  = s_r.rx_s2;
    s_nxt.ack_s1 = l_r.ack;
    s_nxt.ack_s2 = s_r.ack_s1;
    // completion inputs clear first so a same-cycle set below wins
    if (ram_update_done_in) begin
      s_nxt.chem_chg = 1'b0;
    end
    if (init_done_in) begin
      s_nxt.init = 1'b0;
    end
    // byte writes other than the control high byte
    if (wr_evt && !s_r.pdn) begin
      case (l_r.waddr)
        GCS_ADDR_CTRL_LO: s_nxt.cmd_lo = l_r.wdata;
        GCS_ADDR_TEMP_LO: s_nxt.temp_lo = l_r.wdata;
        GCS_ADDR_TEMP_HI: begin
          if (host_temperature_select_in) begin
            s_nxt.temp_host = {l_r.wdata, s_r.temp_lo};
          end
        end
        default: ;
      endcase
    end
    // the control word completes on its high byte
    if (ctl_fire) begin
      if (code < GCS_LAST_LIMIT) begin
        s_nxt.last = code;
      end
      case (code)
        GCS_SC_FW_REV:   s_nxt.resp = FW_REVISION;
        GCS_SC_LAST_CMD: s_nxt.resp = s_r.last;
        GCS_SC_PROFILE: begin
          case (s_r.chem)
            GCS_CHEM_ALT1: s_nxt.resp = PROFILE_ID1;
            GCS_CHEM_ALT2: s_nxt.resp = PROFILE_ID2;
            default:       s_nxt.resp = PROFILE_ID0;
          endcase
        end
        GCS_SC_PRES_ASSERT: begin
          if (!pin_presence_detect_enable_in) begin
            s_nxt.battery_present_flag = 1'b1;
          end
        end
        GCS_SC_PRES_DEASRT: begin
          if (!pin_presence_detect_enable_in) begin
            s_nxt.battery_present_flag = 1'b0;
          end
        end
        GCS_SC_LOWPOW_INV: s_nxt.min_pow = ~s_r.min_pow;
        GCS_SC_SLEEP_REQ:  s_nxt.hib_req = 1'b1;
        GCS_SC_SLEEP_CAN: begin
          s_nxt.hib_req = 1'b0;
          s_nxt.hib_act = 1'b0;
        end
        GCS_SC_CFG_ENTER: begin
          if (open_ok) begin
            s_nxt.cfg = 1'b1;
          end
        end
        GCS_SC_PDN_ARM: s_nxt.armed = 1'b1;
        GCS_SC_PDN_GO: begin
          if (s_r.armed) begin
            s_nxt.pdn       = 1'b1;
            s_nxt.pulse_cnt = '0;
            s_nxt.gp_oe_n   = 1'b1;
          end
        end
        GCS_SC_SEAL: s_nxt.sealed = 1'b1;
        GCS_SC_OUT_PULSE: begin
          if (charge_int_function_in && !low_battery_output_option_in) begin
            s_nxt.pulse_cnt = PULSE_CW'(PULSE_W);
          end
        end
        GCS_SC_ALT_ONE, GCS_SC_ALT_TWO: begin
          if (open_ok && s_r.cfg) begin
            s_nxt.chem     = (code == GCS_SC_ALT_ONE) ? GCS_CHEM_ALT1 : GCS_CHEM_ALT2;
            s_nxt.chem_chg = 1'b1;
          end
        end
        GCS_SC_FULL_RST: begin
          if (open_ok) begin
            restore        = 1'b1;
            s_nxt.full_rst = 1'b1;
          end
        end
        GCS_SC_SOFT_RST, GCS_SC_CFG_PLAIN, GCS_SC_CFG_RESIM: begin
          if (open_ok) begin
            s_nxt.por   = 1'b0;
            s_nxt.cfg   = 1'b0;
            s_nxt.ocv   = code == GCS_SC_SOFT_RST;
            s_nxt.resim = code != GCS_SC_CFG_PLAIN;
          end
        end
        default: ;
      endcase
    end
    // pin-based presence: falling edge of the synchronised pin
    if (pin_presence_detect_enable_in && s_r.bin_s3 && !s_r.bin_s2 && !s_r.pdn) begin
      s_nxt.battery_present_flag = 1'b1;
    end
    // hibernate entry and self-clearing request on exit
    if (s_r.hib_act && hibernate_exit_in) begin
      s_nxt.hib_act = 1'b0;
      s_nxt.hib_req = 1'b0;
    end else if (!s_r.hib_act && s_r.hib_req && sleep_detected_in && !ctl_fire) begin
      s_nxt.hib_act = 1'b1;
    end
    // output pulse: drive low while the count runs; power-down zeroes it above, so never wrap
    if (s_r.pulse_cnt != '0 && s_nxt.pulse_cnt != '0) begin
      s_nxt.pulse_cnt = s_nxt.pulse_cnt - 1'b1;
      s_nxt.gp_oe_n   = 1'b0;
    end else if (!(ctl_fire && code == GCS_SC_OUT_PULSE)) begin
      s_nxt.gp_oe_n = 1'b1;
    end
    // wake from power-down on a rising edge at the output pin
    if (s_r.pdn && !s_r.gp_s3 && s_r.gp_s2) begin
      restore = 1'b1;
    end
    // defaults as after power-on; seal state is kept by a full reset
    if (restore) begin
      s_nxt.battery_present_flag   = 1'b0;
      s_nxt.min_pow   = 1'b0;
      s_nxt.hib_req   = 1'b0;
      s_nxt.hib_act   = 1'b0;
      s_nxt.cfg       = 1'b0;
      s_nxt.armed     = 1'b0;
      s_nxt.pdn       = 1'b0;
      s_nxt.chem      = GCS_CHEM_BASE;
      s_nxt.chem_chg  = 1'b0;
      s_nxt.temp_host = '0;
      s_nxt.pulse_cnt = '0;
      s_nxt.gp_oe_n   = 1'b1;
      s_nxt.por       = 1'b1;
      s_nxt.init      = 1'b1;
    end
    // gauging runs with a battery present and power up
    s_nxt.gauging = s_nxt.battery_present_flag && !s_nxt.pdn;
    // refresh snapshot only once the link has acknowledged the last one
    if (s_r.ack_s2 == s_r.snap_tgl) begin
      s_nxt.snap     = {volt_clamped, temp_rd, s_r.resp};
      s_nxt.snap_tgl = ~s_r.snap_tgl;
    end
  end

  // system registers; power-on sets the power-on flag and init mode
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r         <= '0;
      s_r.gp_oe_n <= 1'b1;
      s_r.por     <= 1'b1;
      s_r.init    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // outputs, all straight from flip-flops
  assign link_rdata_out                 = l_r.rdata;
  assign general_output_pin_out         = s_r.full_rst & 1'b0;  // open drain: only ever pulls low
  assign general_output_pin_oe_n_out    = s_r.gp_oe_n;
  assign battery_present_flag_out       = s_r.battery_present_flag;
  assign gauging_active_out             = s_r.gauging;
  assign min_power_bit_out              = s_r.min_pow;
  assign deep_sleep_request_out         = s_r.hib_req;
  assign hibernate_active_out           = s_r.hib_act;
  assign config_mode_flag_out           = s_r.cfg;
  assign powerdown_armed_bit_out        = s_r.armed;
  assign powerdown_active_out           = s_r.pdn;
  assign sealed_out                     = s_r.sealed;
  assign profile_change_pending_bit_out = s_r.chem_chg;
  assign power_on_reset_flag_out        = s_r.por;
  assign init_mode_out                  = s_r.init;
  assign profile_select_out             = s_r.chem;
  assign full_reset_out                 = s_r.full_rst;
  assign ocv_measure_out                = s_r.ocv;
  assign resimulate_out                 = s_r.resim;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_cmd(logic [15:0] c);
    ctl_fire && code == c;
  endsequence

  sequence s_left_cfg;
    !s_r.por && !s_r.cfg;
  endsequence

  property p_last_below;
    s_r.last < GCS_LAST_LIMIT;
  endproperty
  a_last_below: assert property (p_last_below) else $error("last command not below limit");

  property p_insert;
    s_cmd(GCS_SC_PRES_ASSERT) ##0 !pin_presence_detect_enable_in |=> s_r.battery_present_flag ##1 s_r.gauging;
  endproperty
  a_insert: assert property (p_insert) else $error("presence assert not taken");

  property p_minpow;
    s_cmd(GCS_SC_LOWPOW_INV) |=> s_r.min_pow != $past(s_r.min_pow);
  endproperty
  a_minpow: assert property (p_minpow) else $error("min power bit not inverted");

  property p_sealed_cfg;
    s_cmd(GCS_SC_CFG_ENTER) ##0 s_r.sealed ##0 !s_r.cfg |=> !s_r.cfg;
  endproperty
  a_sealed_cfg: assert property (p_sealed_cfg) else $error("config entry while sealed");

  property p_pdn_armed;
    $rose(s_r.pdn) |-> $past(s_r.armed);
  endproperty
  a_pdn_armed: assert property (p_pdn_armed) else $error("power-down without arming");

  property p_wake;
    s_r.pdn && !s_r.gp_s3 && s_r.gp_s2 |=> !s_r.pdn && s_r.por && !s_r.armed;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not restore defaults");

  property p_pulse_len;
    $fell(s_r.gp_oe_n) |-> s_r.pulse_cnt == PULSE_CW'(PULSE_W - 1);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length start wrong");

  property p_alt_one;
    s_cmd(GCS_SC_ALT_ONE) ##0 !s_r.sealed ##0 s_r.cfg |=> s_r.chem_chg && s_r.chem == GCS_CHEM_ALT1;
  endproperty
  a_alt_one: assert property (p_alt_one) else $error("alternate profile not selected");

  property p_soft;
    s_cmd(GCS_SC_SOFT_RST) ##0 !s_r.sealed |=> s_left_cfg ##0 s_r.ocv && s_r.resim ##1 !s_r.ocv;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset effect wrong");

  property p_plain_exit;
    s_cmd(GCS_SC_CFG_PLAIN) ##0 !s_r.sealed |=> s_left_cfg ##0 !s_r.ocv && !s_r.resim;
  endproperty
  a_plain_exit: assert property (p_plain_exit) else $error("plain config exit effect wrong");

  property p_volt;
    s_r.snap[GCS_SNAP_VOLT +: 16] <= GCS_VOLT_MAX_MV;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage above limit");

endmodule // gcs_subcommand_unit

// file: tb/gcs_host_model.sv
// ==========
// host side of the link byte port
module gcs_host_model (
  input  wire logic       link_clk_in,
  output logic            wr_out = 1'b0,
  output logic            rd_out = 1'b0,
  output logic [7:0]      addr_out = 8'h00,
  output logic [7:0]      wdata_out = 8'h00,
  output logic            rd_done_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // one byte per call; lines flip when released so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge link_clk_in) #1;
    wr_out = w;
    rd_out = !w;
    addr_out = a;
    wdata_out = w ? d : ~d;
    @(posedge link_clk_in) #1;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~wdata_out;
    rd_done_out = !w;  // read byte valid after the read edge
    @(posedge link_clk_in) #1;
    rd_done_out = 1'b0;
  endtask
endmodule  // gcs_host_model

// file: tb/gcs_subcommand_unit_tb_top.sv
module gcs_subcommand_unit_tb_top;
  import gcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] FW = 16'h0321;  // arbitrary value
  localparam logic [15:0] PID [3] = '{16'h0a11, 16'h0a22, 16'h0a33};  // arbitrary values
  logic        sys_clk = 0, link_clk = 0, rst_n = 0, wr, rd, rd_done, gp_ext = 1;
  logic        host_t = 0, sleep = 0, hexit = 0, ram_done = 0, pin_presence_detect_enable = 0, bin_pin = 1, lowbat = 0, idone = 0;
  logic        gp_o, ocv;
  logic [7:0]  addr, wdata, rdata, q[$];
  logic [15:0] itemp = 0, volt = 0;
  logic        oe_n, bat, gaug, minp, dsr, hib, cfg, arm, pdn, seal, chg, por, initm, full_rst, resim;
  logic [1:0]  psel;
  int          error_cnt = 0, n_compared = 0, n_full = 0, n_resim = 0, n_low = 0, n_ocv = 0;
  // ==========
  // clocks, pulse counters
  always #2.5 sys_clk = ~sys_clk;
  initial #7 forever #62.5 link_clk = ~link_clk;
  always @(posedge sys_clk) begin
    n_full <= n_full + full_rst;
    n_resim <= n_resim + resim;
    n_ocv <= n_ocv + ocv;
    n_low <= n_low + (rst_n && oe_n === 1'b0);
  end
  gcs_host_model u_gcs_host_model (.link_clk_in(link_clk), .wr_out(wr), .rd_out(rd), .addr_out(addr),
    .wdata_out(wdata), .rd_done_out(rd_done));
  gcs_subcommand_unit #(.PULSE_W(20), .FW_REVISION(FW), .PROFILE_ID0(PID[0]), .PROFILE_ID1(PID[1]),
    .PROFILE_ID2(PID[2])) u_gcs_subcommand_unit (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .link_clk_in(link_clk), .link_wr_in(wr), .link_rd_in(rd), .link_addr_in(addr), .link_wdata_in(wdata),
    .link_rdata_out(rdata), .pin_presence_detect_enable_in(pin_presence_detect_enable), .host_temperature_select_in(host_t),
    .low_battery_output_option_in(lowbat), .charge_int_function_in(1'b1), .internal_temp_in(itemp),
    .pack_voltage_in(volt), .sleep_detected_in(sleep), .hibernate_exit_in(hexit),
    .ram_update_done_in(ram_done), .init_done_in(idone), .battery_insert_pin_in(bin_pin),
    .general_output_pin_in(oe_n & gp_ext), .general_output_pin_out(gp_o), .general_output_pin_oe_n_out(oe_n),
    .battery_present_flag_out(bat), .gauging_active_out(gaug), .min_power_bit_out(minp),
    .deep_sleep_request_out(dsr), .hibernate_active_out(hib), .config_mode_flag_out(cfg),
    .powerdown_armed_bit_out(arm), .powerdown_active_out(pdn), .sealed_out(seal),
    .profile_change_pending_bit_out(chg), .power_on_reset_flag_out(por), .init_mode_out(initm),
    .profile_select_out(psel), .full_reset_out(full_rst), .ocv_measure_out(ocv), .resimulate_out(resim));
  // ==========
  // compares, shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t status %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] exp);
    n_compared++;
    if (rdata !== exp) begin
      error_cnt++;
      $display("[ERR] %0t read %h expected %h", $time, rdata, exp);
    end
  endtask
  always @(posedge rd_done) chk_rd(q.pop_front());
  // snapshot may lag by about six link cycles
  task automatic settle();
    repeat (12) @(posedge link_clk);
    @(posedge sys_clk) #1;
  endtask
  task automatic cmd(input logic [15:0] c);
    u_gcs_host_model.xfer(1, GCS_ADDR_CTRL_LO, c[7:0]);
    u_gcs_host_model.xfer(1, GCS_ADDR_CTRL_HI, c[15:8]);
    settle();
  endtask
  task automatic wrw(input logic [7:0] a, input logic [15:0] d);
    u_gcs_host_model.xfer(1, a, d[7:0]);
    u_gcs_host_model.xfer(1, a + 8'h01, d[15:8]);
    settle();
  endtask
  task automatic rdw(input logic [7:0] a, input logic [15:0] e);
    q.push_back(e[7:0]);
    u_gcs_host_model.xfer(0, a, 8'h00);
    q.push_back(e[15:8]);
    u_gcs_host_model.xfer(0, a + 8'h01, 8'h00);
  endtask
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    error_cnt++;
    test_done();
  end
  // ==========
  // main sequence
  initial begin
    void'($urandom(3));
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1;
    chk({oe_n, gp_o, por, initm, bat}, 5'b10110);
    cmd(GCS_SC_FW_REV);
    rdw(GCS_ADDR_CTRL_LO, FW);
    cmd(GCS_SC_LOWPOW_INV);
    chk(minp, 1'b1);
    cmd(GCS_SC_LAST_CMD);
    rdw(GCS_ADDR_CTRL_LO, GCS_SC_LOWPOW_INV);
    cmd(GCS_SC_PRES_ASSERT);
    chk({bat, gaug}, 2'b11);
    cmd(GCS_SC_PRES_DEASRT);
    chk(bat, 1'b0);
    // pin detect on: presence commands refused, falling pin edge sets the flag
    pin_presence_detect_enable = 1;
    cmd(GCS_SC_PRES_ASSERT);
    chk(bat, 1'b0);
    bin_pin = 0;
    settle();
    chk({bat, gaug}, 2'b11);
    cmd(GCS_SC_PRES_DEASRT);
    chk(bat, 1'b1);
    pin_presence_detect_enable = 0;
    cmd(GCS_SC_PRES_DEASRT);
    bin_pin = 1;
    settle();
    bin_pin = 0;
    settle();
    chk(bat, 1'b0);
    cmd(GCS_SC_SLEEP_REQ);
    sleep = 1;
    settle();
    chk({dsr, hib}, 2'b11);
    cmd(GCS_SC_SLEEP_CAN);
    chk({dsr, hib}, 2'b00);
    cmd(GCS_SC_SLEEP_REQ);
    hexit = 1;
    settle();
    chk({dsr, hib}, 2'b00);
    {sleep, hexit} = 2'b00;
    cmd(GCS_SC_ALT_TWO);
    chk(psel, 2'b00);
    cmd(GCS_SC_CFG_ENTER);
    chk(cfg, 1'b1);
    cmd(GCS_SC_ALT_ONE);
    chk({psel, chg}, 3'b011);
    ram_done = 1;
    @(posedge sys_clk) #1 ram_done = 0;
    settle();
    chk(chg, 1'b0);
    cmd(GCS_SC_PROFILE);
    rdw(GCS_ADDR_CTRL_LO, PID[1]);
    cmd(GCS_SC_CFG_PLAIN);
    chk({cfg, por, 8'(n_resim)}, 10'h000);
    cmd(GCS_SC_CFG_RESIM);
    chk({8'(n_ocv), 8'(n_resim)}, 16'h0001);
    cmd(GCS_SC_SOFT_RST);
    chk({8'(n_ocv), 8'(n_resim)}, 16'h0102);
    cmd(GCS_SC_FULL_RST);
    chk({por, initm, 8'(n_full)}, 10'h301);
    idone = 1;
    @(posedge sys_clk) #1 idone = 0;
    chk(initm, 1'b0);
    itemp = 16'($urandom_range(3500, 2000));
    volt = 16'($urandom_range(9000, 6001));
    wrw(GCS_ADDR_TEMP_LO, ~itemp);
    rdw(GCS_ADDR_TEMP_LO, itemp);
    rdw(GCS_ADDR_VOLT_LO, GCS_VOLT_MAX_MV);
    host_t = 1;
    volt = 16'($urandom_range(6000, 0));
    wrw(GCS_ADDR_TEMP_LO, ~itemp);
    rdw(GCS_ADDR_TEMP_LO, ~itemp);
    rdw(GCS_ADDR_VOLT_LO, volt);
    lowbat = 1;
    cmd(GCS_SC_OUT_PULSE);
    chk({oe_n, 8'(n_low)}, 9'h100);
    lowbat = 0;
    cmd(GCS_SC_OUT_PULSE);
    chk({oe_n, 8'(n_low)}, 9'h114);
    cmd(GCS_SC_PRES_ASSERT);
    cmd(GCS_SC_PDN_GO);
    chk(pdn, 1'b0);
    cmd(GCS_SC_PDN_ARM);
    chk(arm, 1'b1);
    cmd(GCS_SC_PDN_GO);
    chk({pdn, gaug}, 2'b10);
    gp_ext = 0;
    settle();
    gp_ext = 1;
    settle();
    chk({pdn, por}, 2'b01);
    cmd(GCS_SC_SEAL);
    chk(seal, 1'b1);
    cmd(GCS_SC_CFG_ENTER);
    chk(cfg, 1'b0);
    cmd(GCS_SC_SOFT_RST);
    cmd(GCS_SC_FULL_RST);
    chk({8'(n_full), 8'(n_ocv)}, 16'h0101);
    chk(por, 1'b1);
    test_done();
  end
endmodule  // gcs_subcommand_unit_tb_top
